// file: rtl/pms_status_regs.sv
/*
 * management register bank, registers 1 to 6: basic status, identifier,
 * auto-negotiation advertisement, partner ability and expansion.
 * assumes the serial frame engine on clk_sys presents a decoded address
 * with one-cycle read and write strobes, and that the auto-negotiation
 * engine supplies its results on clk_sys. link and jabber come from the
 * analog front end and are synchronised here.
 */
`timescale 1ns/100ps
`default_nettype none
module pms_status_regs #(
    parameter logic [15:0] PHY_ID_HIGH = pms_pkg::ID_HIGH_DEFAULT,
    parameter logic [15:0] PHY_ID_LOW = pms_pkg::ID_LOW_DEFAULT
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    // register access from the serial frame engine
    input wire logic [pms_pkg::ADDR_W-1:0] regAddr,
    input wire logic regRdEn,
    input wire logic regWrEn,
    input wire logic [pms_pkg::DATA_W-1:0] regWrData,
    output logic [pms_pkg::DATA_W-1:0] regRdData,
    output logic regRdValid,
    // front end levels, asynchronous
    input wire logic linkLiveIn,
    input wire logic jabberLiveIn,
    // auto-negotiation engine results
    input wire logic anDoneIn,
    input wire logic [pms_pkg::DATA_W-1:0] lpPageIn,
    input wire logic lpAckIn,
    input wire logic lpAnAbleIn,
    input wire logic lpNpAbleIn,
    input wire logic localNpAbleIn,
    input wire logic pdFaultEvt,
    input wire logic pageRcvdEvt,
    // advertised page toward the engine
    output logic [pms_pkg::DATA_W-1:0] advWord,
    output logic advRemoteFault
);
    import pms_pkg::*;

    // ************************************************************
    // address decode
    // ************************************************************

    // shared decode of a strobe at one address
    function automatic logic hitAt(
        input logic strobe,
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] target
    );
        hitAt = strobe && (addr == target);
    endfunction

    // only these three strobes have side effects; other reads are pure
    logic rdStatus;
    logic rdExpand;
    logic wrAdvert;

    assign rdStatus = hitAt(regRdEn, regAddr, ADDR_STATUS);
    assign rdExpand = hitAt(regRdEn, regAddr, ADDR_EXPAND);
    assign wrAdvert = hitAt(regWrEn, regAddr, ADDR_ADVERT);

    // ************************************************************
    // input conditioning
    // ************************************************************

    logic [1:0] frontSync;
    logic linkLive;
    logic jabberLive;

    // front end levels cross into clk_sys before anything reads them
    // a change reaches the latch on the third edge after it lands
    pms_sync2 #(
        .WIDTH(2)
    ) u_front_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .asyncIn({linkLiveIn, jabberLiveIn}),
        .syncOut(frontSync)
    );

    assign linkLive = frontSync[1];
    assign jabberLive = frontSync[0];

    // ************************************************************
    // latching flags
    // ************************************************************

    // four copies of one cell; only polarity and clearing read differ
    logic linkFlag;
    logic jabberFlag;
    logic pdFaultFlag;
    logic pageRcvdFlag;

    // link drops are held until status is read
    pms_latch_bit #(
        .LATCH_LOW(1'b1)
    ) u_link_latch (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .liveIn(linkLive),
        .clearRd(rdStatus),
        .flagOut(linkFlag)
    );

    // jabber is held until status is read
    pms_latch_bit #(
        .LATCH_LOW(1'b0)
    ) u_jabber_latch (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .liveIn(jabberLive),
        .clearRd(rdStatus),
        .flagOut(jabberFlag)
    );

    // parallel detection fault, cleared by reading expansion
    pms_latch_bit #(
        .LATCH_LOW(1'b0)
    ) u_pd_fault_latch (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .liveIn(pdFaultEvt),
        .clearRd(rdExpand),
        .flagOut(pdFaultFlag)
    );

    // new page received, cleared by reading expansion
    pms_latch_bit #(
        .LATCH_LOW(1'b0)
    ) u_page_latch (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .liveIn(pageRcvdEvt),
        .clearRd(rdExpand),
        .flagOut(pageRcvdFlag)
    );

    // ************************************************************
    // live status captured from the engine
    // ************************************************************

    logic anDone_reg;
    logic lpAck_reg;
    logic lpAnAble_reg;
    logic lpNpAble_reg;
    logic npAble_reg;

    // completion flag, zero after reset until the engine reports done
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            anDone_reg <= 1'b0;
        else
            anDone_reg <= anDoneIn;
    end

    // partner acknowledge, kept apart from the mirrored page
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            lpAck_reg <= 1'b0;
        else
            lpAck_reg <= lpAckIn;
    end

    // partner abilities, registered so a read sees one coherent edge
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lpAnAble_reg <= 1'b0;
            lpNpAble_reg <= 1'b0;
        end
        else
        begin
            lpAnAble_reg <= lpAnAbleIn;
            lpNpAble_reg <= lpNpAbleIn;
        end
    end

    // local next-page ability, zero after reset
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            npAble_reg <= 1'b0;
        else
            npAble_reg <= localNpAbleIn;
    end

    logic [DATA_W-1:0] lpPage_reg;

    // partner page mirrored as received; no write path exists
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            lpPage_reg <= WORD_ZERO;
        else
            lpPage_reg <= lpPageIn;
    end

    // ************************************************************
    // advertisement register
    // ************************************************************

    logic advFault_reg;
    logic [TECH_W-1:0] advTech_reg;

    // only fault and ability bits take writes; other fields stay fixed
    // a read in the write cycle still returns the old word
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            advFault_reg <= AD_FAULT_RESET;
            advTech_reg <= AD_TECH_RESET;
        end
        else if (wrAdvert)
        begin
            advFault_reg <= regWrData[AD_REMOTE_FAULT];
            advTech_reg <= regWrData[AD_TECH_HI:AD_TECH_LO];
        end
    end

    // ************************************************************
    // read word assembly
    // ************************************************************

    logic [DATA_W-1:0] statusWord;
    logic [DATA_W-1:0] advertWord;
    logic [DATA_W-1:0] partnerWord;
    logic [DATA_W-1:0] expandWord;

    // basic status: fixed capabilities around the latched flags
    always_comb
    begin
        statusWord = WORD_ZERO;
        statusWord[ST_CAP_HI:ST_CAP_LO] = 4'hf;
        statusWord[ST_PREAMBLE] = 1'b0;
        statusWord[ST_AN_DONE] = anDone_reg;
        statusWord[ST_REMOTE_FAULT] = 1'b0;
        statusWord[ST_AN_ABLE] = 1'b1;
        statusWord[ST_LINK] = linkFlag;
        statusWord[ST_JABBER] = jabberFlag;
        statusWord[ST_EXT_CAP] = 1'b1;
    end

    // advertisement: next page and reserved bit stay zero
    always_comb
    begin
        advertWord = WORD_ZERO;
        advertWord[AD_REMOTE_FAULT] = advFault_reg;
        advertWord[AD_TECH_HI:AD_TECH_LO] = advTech_reg;
        advertWord[AD_SEL_HI:0] = AD_SEL_VALUE;
    end

    // partner: acknowledge comes from the engine, not the page
    always_comb
    begin
        partnerWord = lpPage_reg;
        partnerWord[LP_ACK] = lpAck_reg;
    end

    // expansion: upper bits reserved
    always_comb
    begin
        expandWord = WORD_ZERO;
        expandWord[EX_PD_FAULT] = pdFaultFlag;
        expandWord[EX_LP_NP_ABLE] = lpNpAble_reg;
        expandWord[EX_NP_ABLE] = npAble_reg;
        expandWord[EX_PAGE_RCVD] = pageRcvdFlag;
        expandWord[EX_LP_AN_ABLE] = lpAnAble_reg;
    end

    logic [DATA_W-1:0] readMux;

    // unmapped addresses read zero; the frame engine owns the others
    // decoded on the address alone, so the strobe only gates capture
    always_comb
    begin
        case (regAddr)
            ADDR_STATUS: readMux = statusWord;
            ADDR_ID_HIGH: readMux = PHY_ID_HIGH;
            ADDR_ID_LOW: readMux = PHY_ID_LOW;
            ADDR_ADVERT: readMux = advertWord;
            ADDR_PARTNER: readMux = partnerWord;
            ADDR_EXPAND: readMux = expandWord;
            default: readMux = WORD_ZERO;
        endcase
    end

    // ************************************************************
    // output registers
    // ************************************************************

    logic [DATA_W-1:0] rdData_reg;
    logic rdValid_reg;

    // valid follows every read strobe by exactly one edge
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            rdValid_reg <= 1'b0;
        else
            rdValid_reg <= regRdEn;
    end

    // data is captured in the same edge that reloads latched flags,
    // so the word returned holds the value before the reload
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            rdData_reg <= WORD_ZERO;
        else if (regRdEn)
            rdData_reg <= readMux;
    end

    logic [DATA_W-1:0] advWord_reg;
    logic advRemoteFault_reg;

    // advertised page to the engine, one edge behind the register
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            advWord_reg <= WORD_ZERO;
        else
            advWord_reg <= advertWord;
    end

    // remote fault on its own wire, same edge as the page
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            advRemoteFault_reg <= 1'b0;
        else
            advRemoteFault_reg <= advFault_reg;
    end

    assign regRdData = rdData_reg;
    assign regRdValid = rdValid_reg;
    assign advWord = advWord_reg;
    assign advRemoteFault = advRemoteFault_reg;

endmodule
`default_nettype wire

// file: inc/pms_pkg.sv
/*
 * constants for the management status / auto-negotiation register bank:
 * register addresses, field positions, reset values and fixed read values.
 * assumes a 5-bit register address delivered by the serial frame engine.
 */
// Overview of operation
// - status bits 14:11 always read one
// - status bit 6 reads zero, preamble needed
// - status bit 5 shows auto-negotiation done
// - status bit 4 remote fault reads zero
// - status bit 3 always reads one
// - status bit 2 link, latch on low
// - status bit 1 jabber, latch on high
// - status bit 0 always reads one
// - status bits 15, 10:7 read zero
// - registers 2, 3 fixed identifier, writes ignored
// - advert bits 15, 14 read zero
// - advert bit 13 writable remote fault
// - advert bits 12:5 writable, reset 00101111
// - advert bits 4:0 fixed 00001
// - partner register mirrors received partner page
// - partner bit 14 shows page acknowledged
// - expansion bit 4 fault, clears on read
// - expansion bit 1 page, clears on read
// - expansion bit 3 partner next-page able
// - expansion bit 2 local next-page able
// - expansion bit 0 partner negotiation able
// - expansion bits 15:5 read zero
package pms_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int TECH_W = 8;
    localparam int SEL_W = 5;

    // register addresses
    localparam logic [4:0] ADDR_STATUS = 5'h01;
    localparam logic [4:0] ADDR_ID_HIGH = 5'h02;
    localparam logic [4:0] ADDR_ID_LOW = 5'h03;
    localparam logic [4:0] ADDR_ADVERT = 5'h04;
    localparam logic [4:0] ADDR_PARTNER = 5'h05;
    localparam logic [4:0] ADDR_EXPAND = 5'h06;

    // status register fields
    localparam int ST_CAP_HI = 14;
    localparam int ST_CAP_LO = 11;
    localparam int ST_PREAMBLE = 6;
    localparam int ST_AN_DONE = 5;
    localparam int ST_REMOTE_FAULT = 4;
    localparam int ST_AN_ABLE = 3;
    localparam int ST_LINK = 2;
    localparam int ST_JABBER = 1;
    localparam int ST_EXT_CAP = 0;

    // advertisement fields
    localparam int AD_NEXT_PAGE = 15;
    localparam int AD_REMOTE_FAULT = 13;
    localparam int AD_TECH_HI = 12;
    localparam int AD_TECH_LO = 5;
    localparam int AD_SEL_HI = 4;
    localparam logic [7:0] AD_TECH_RESET = 8'h2f;
    localparam logic [4:0] AD_SEL_VALUE = 5'h01;
    localparam logic AD_FAULT_RESET = 1'b0;

    // partner ability fields
    localparam int LP_ACK = 14;

    // expansion fields
    localparam int EX_PD_FAULT = 4;
    localparam int EX_LP_NP_ABLE = 3;
    localparam int EX_NP_ABLE = 2;
    localparam int EX_PAGE_RCVD = 1;
    localparam int EX_LP_AN_ABLE = 0;

    // identifier defaults, arbitrary values
    localparam logic [15:0] ID_HIGH_DEFAULT = 16'h1234;
    localparam logic [15:0] ID_LOW_DEFAULT = 16'h5678;

    localparam logic [15:0] WORD_ZERO = 16'h0000;

endpackage

// file: rtl/pms_sync2.sv
/*
 * two-flop synchroniser for a bundle of independent level signals.
 * assumes each bit is a slow level; no bus coherency is promised.
 */
`timescale 1ns/100ps
`default_nettype none
module pms_sync2 #(
    parameter int WIDTH = 2
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    import pms_pkg::*;

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // first stage is read only by the second stage
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end
        else
        begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign syncOut = stage2_reg;

endmodule
`default_nettype wire

// file: rtl/pms_latch_bit.sv
/*
 * one latching status flag: latch on low or latch on high.
 * a read reloads the flag from the live level, so a new event in the
 * read cycle is kept. assumes clearRd is a one-cycle pulse.
 */
`timescale 1ns/100ps
`default_nettype none
module pms_latch_bit #(
    parameter bit LATCH_LOW = 1'b0
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic liveIn,
    input wire logic clearRd,
    output logic flagOut
);
    import pms_pkg::*;

    logic flag_reg;
    logic flag_next;

    // latch on low holds a zero, latch on high holds a one
    always_comb
    begin
        if (clearRd)
            flag_next = liveIn;
        else if (LATCH_LOW)
            flag_next = flag_reg & liveIn;
        else
            flag_next = flag_reg | liveIn;
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            flag_reg <= 1'b0;
        else
            flag_reg <= flag_next;
    end

    assign flagOut = flag_reg;

endmodule
`default_nettype wire

// file: verification/pms_status_regs_asserts.sv
/* checker for the status / auto-negotiation register bank.
   assumes it is bound to pms_status_regs and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module pms_status_regs_asserts #(
    parameter logic [15:0] PHY_ID_HIGH = 16'h0000,
    parameter logic [15:0] PHY_ID_LOW = 16'h0000
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [4:0] regAddr,
    input wire logic regRdEn,
    input wire logic regWrEn,
    input wire logic [15:0] regWrData,
    input wire logic [15:0] regRdData,
    input wire logic regRdValid,
    input wire logic linkLiveIn,
    input wire logic jabberLiveIn,
    input wire logic anDoneIn,
    input wire logic [15:0] lpPageIn,
    input wire logic lpAckIn,
    input wire logic lpAnAbleIn,
    input wire logic lpNpAbleIn,
    input wire logic localNpAbleIn,
    input wire logic pdFaultEvt,
    input wire logic pageRcvdEvt,
    input wire logic [15:0] advWord,
    input wire logic advRemoteFault
);
    import pms_pkg::*;
    // ********
    // decoded accesses
    // ********
    wire logic rd1 = regRdEn && regAddr == ADDR_STATUS;
    wire logic rdId = regRdEn && (regAddr == ADDR_ID_HIGH || regAddr == ADDR_ID_LOW);
    wire logic rd5 = regRdEn && regAddr == ADDR_PARTNER;
    wire logic rd6 = regRdEn && regAddr == ADDR_EXPAND;
    wire logic wr4 = regWrEn && regAddr == ADDR_ADVERT;
    wire logic evt = pdFaultEvt || pageRcvdEvt;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    // read data is judged one edge after the read strobe
    a_status_fixed: assert property (rd1 |=> regRdData[15:6] == 10'h1e0
        && regRdData[4:3] == 2'h1 && regRdData[0]) else $error("status fixed bits wrong");
    a_an_done: assert property ($past(rst_b) && rd1 && $stable(anDoneIn)
        |=> regRdData[5] == $past(anDoneIn)) else $error("completion bit wrong");
    a_link_low: assert property (!linkLiveIn ##1 !regRdEn [*2] ##1 rd1
        |=> !regRdData[2]) else $error("link drop not held");
    a_jabber_high: assert property (jabberLiveIn ##1 !regRdEn [*2] ##1 rd1
        |=> regRdData[1]) else $error("jabber not held");
    a_id_fixed: assert property (rdId |=> regRdData ==
        ($past(regAddr) == ADDR_ID_HIGH ? PHY_ID_HIGH : PHY_ID_LOW)) else $error("identifier wrong");
    a_adv_fixed: assert property ($past(rst_b) |-> advWord[15:14] == 2'h0
        && advWord[4:0] == AD_SEL_VALUE && advRemoteFault == advWord[13]) else $error("advert fixed bits wrong");
    a_adv_write: assert property (wr4 ##1 !regWrEn
        |=> advWord[13:5] == $past(regWrData[13:5], 2)) else $error("advert write lost");
    a_lp_mirror: assert property ($past(rst_b) && rd5 && $stable(lpPageIn) && $stable(lpAckIn)
        |=> regRdData == {$past(lpPageIn[15]), $past(lpAckIn), $past(lpPageIn[13:0])}) else $error("partner word wrong");
    a_exp_live: assert property ($past(rst_b) && rd6 && $stable({lpNpAbleIn, localNpAbleIn, lpAnAbleIn})
        |=> regRdData[15:5] == 11'h000 && regRdData[3:2] == $past({lpNpAbleIn, localNpAbleIn})
        && regRdData[0] == $past(lpAnAbleIn)) else $error("expansion live bits wrong");
    a_evt_latch: assert property ((pageRcvdEvt && pdFaultEvt) ##1 !regRdEn ##1 rd6
        |=> regRdData[4] && regRdData[1]) else $error("event not latched");
    a_evt_clear: assert property ((rd6 && !evt) ##1 !evt ##1 (rd6 && !evt)
        |=> !regRdData[4] && !regRdData[1]) else $error("event not cleared by read");
    // one answer per read strobe; data stands between answers
    a_valid_pulse: assert property (regRdValid == $past(regRdEn)) // read handshake
        else $error("read valid not one cycle after strobe");
    a_data_hold: assert property (!regRdValid |-> $stable(regRdData)) // read handshake
        else $error("read data moved without a read");
endmodule
bind pms_status_regs pms_status_regs_asserts #(.PHY_ID_HIGH(PHY_ID_HIGH), .PHY_ID_LOW(PHY_ID_LOW))
    pms_status_regs_asserts_i (.clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr), .regRdEn(regRdEn),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
    .linkLiveIn(linkLiveIn), .jabberLiveIn(jabberLiveIn), .anDoneIn(anDoneIn), .lpPageIn(lpPageIn),
    .lpAckIn(lpAckIn),
    .lpAnAbleIn(lpAnAbleIn), .lpNpAbleIn(lpNpAbleIn), .localNpAbleIn(localNpAbleIn),
    .pdFaultEvt(pdFaultEvt), .pageRcvdEvt(pageRcvdEvt), .advWord(advWord), .advRemoteFault(advRemoteFault));
`default_nettype wire

// file: verification/pms_mgmt_master.sv
/* management master model: one-cycle read and write strobes.
   assumes clk_sys and a bank answering one cycle after a read. */
`timescale 1ns/100ps
`default_nettype none
module pms_mgmt_master (
    input wire logic clk_sys,
    input wire logic [pms_pkg::DATA_W-1:0] regRdData,
    input wire logic regRdValid,
    output var logic [pms_pkg::ADDR_W-1:0] regAddr,
    output var logic regRdEn,
    output var logic regWrEn,
    output var logic [pms_pkg::DATA_W-1:0] regWrData
);
    import pms_pkg::*;
    logic stuck;
    // ********
    // bus cycles
    // ********
    initial
    begin
        stuck = 1'b0;
        regAddr = 5'h1f;
        regRdEn = 1'b0;
        regWrEn = 1'b0;
        regWrData = 16'ha5a5;
    end
    // idle lines show the inverse, so stale data cannot pass
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        #1;
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(posedge clk_sys);
        #1;
        regWrEn = 1'b0;
        regWrData = ~d;
        regAddr = ~a;
    endtask
    // bounded wait for the answer
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        int n;
        @(posedge clk_sys);
        #1;
        regAddr = a;
        regRdEn = 1'b1;
        @(posedge clk_sys);
        #1;
        regRdEn = 1'b0;
        regAddr = ~a;
        n = 0;
        while (regRdValid !== 1'b1 && n < 4)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        // the answer is due exactly one edge after the strobe
        stuck = (n != 0);
        d = regRdData;
    endtask
endmodule
`default_nettype wire

// file: verification/pms_status_regs_tb.sv
/* self-checking bench for the register bank.
   assumes the master model and the bound checker are compiled. */
`timescale 1ns/100ps
`default_nettype none
module pms_status_regs_tb;
    import pms_pkg::*;
    localparam logic [15:0] ID_H = 16'h1234; // arbitrary value
    localparam logic [15:0] ID_L = 16'h5678; // arbitrary value
    logic clk_sys, rst_b, linkLiveIn, jabberLiveIn, anDoneIn, lpAckIn, lpAnAbleIn, lpNpAbleIn;
    logic localNpAbleIn, pdFaultEvt, pageRcvdEvt, regRdEn, regWrEn, regRdValid, advRemoteFault;
    logic [4:0] regAddr;
    logic [15:0] regWrData, regRdData, lpPageIn, advWord;
    logic [4:0] holes [3] = '{5'h00, 5'h07, 5'h1f};
    logic [15:0] wv [2] = '{16'hffff, 16'h0000};
    logic [15:0] lpv [2] = '{16'hc5a3, 16'h3a5c};
    int n_mismatch, checks_done, i;
    // ********
    // instances and clock
    // ********
    pms_status_regs #(.PHY_ID_HIGH(ID_H), .PHY_ID_LOW(ID_L)) pms_status_regs_i (.clk_sys(clk_sys), .rst_b(rst_b),
        .regAddr(regAddr), .regRdEn(regRdEn), .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .linkLiveIn(linkLiveIn), .jabberLiveIn(jabberLiveIn), .anDoneIn(anDoneIn),
        .lpPageIn(lpPageIn), .lpAckIn(lpAckIn), .lpAnAbleIn(lpAnAbleIn), .lpNpAbleIn(lpNpAbleIn),
        .localNpAbleIn(localNpAbleIn), .pdFaultEvt(pdFaultEvt), .pageRcvdEvt(pageRcvdEvt), .advWord(advWord),
        .advRemoteFault(advRemoteFault));
    pms_mgmt_master pms_mgmt_master_i (.clk_sys(clk_sys), .regRdData(regRdData), .regRdValid(regRdValid),
        .regAddr(regAddr), .regRdEn(regRdEn), .regWrEn(regWrEn), .regWrData(regWrData));
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // ********
    // helpers
    // ********
    task automatic final_report();
        if (n_mismatch == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] e);
        checks_done++;
        if (got !== e)
        begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, e);
        end
    endtask
    // a stuck read ends the run at once
    task automatic chk(input logic [4:0] a, input logic [15:0] e);
        logic [15:0] v;
        pms_mgmt_master_i.rd(a, v);
        if (pms_mgmt_master_i.stuck === 1'b1)
        begin
            n_mismatch++;
            final_report();
        end
        cmp(v, e);
    endtask
    // inputs move 1 ns after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // ********
    // scenarios
    // ********
    initial
    begin
        {n_mismatch, checks_done} = '0;
        {rst_b, jabberLiveIn, anDoneIn, lpAckIn, lpAnAbleIn, lpNpAbleIn} = '0;
        {localNpAbleIn, pdFaultEvt, pageRcvdEvt} = '0;
        linkLiveIn = 1'b1;
        lpPageIn = 16'h0000;
        cyc(3);
        rst_b = 1'b1;
        cyc(3);
        chk(ADDR_ADVERT, 16'h05e1);
        chk(ADDR_EXPAND, 16'h0000);
        chk(ADDR_STATUS, 16'h7809);
        chk(ADDR_STATUS, 16'h780d);
        chk(ADDR_ID_HIGH, ID_H);
        pms_mgmt_master_i.wr(ADDR_ID_LOW, 16'hffff);
        chk(ADDR_ID_LOW, ID_L);
        // only remote fault and technology bits take a write
        for (i = 0; i < 2; i++)
        begin
            pms_mgmt_master_i.wr(ADDR_ADVERT, wv[i]);
            chk(ADDR_ADVERT, (wv[i] & 16'h3fe0) | 16'h0001);
            cmp(advWord, (wv[i] & 16'h3fe0) | 16'h0001);
            cmp({15'h0000, advRemoteFault}, {15'h0000, wv[i][13]});
        end
        // short link drop and jabber burst, restored before the read
        {anDoneIn, jabberLiveIn, linkLiveIn} = 3'h6;
        cyc(3);
        {jabberLiveIn, linkLiveIn} = 2'h1;
        cyc(1);
        chk(ADDR_STATUS, 16'h782b);
        chk(ADDR_STATUS, 16'h782d);
        for (i = 0; i < 2; i++)
        begin
            lpPageIn = lpv[i];
            lpAckIn = i[0];
            chk(ADDR_PARTNER, {lpv[i][15], i[0], lpv[i][13:0]});
        end
        // one-cycle events, then clear-on-read
        {lpAnAbleIn, lpNpAbleIn, localNpAbleIn, pdFaultEvt, pageRcvdEvt} = 5'h1f;
        cyc(1);
        {pdFaultEvt, pageRcvdEvt} = 2'h0;
        chk(ADDR_EXPAND, 16'h001f);
        chk(ADDR_EXPAND, 16'h000d);
        {lpAnAbleIn, lpNpAbleIn, localNpAbleIn} = 3'h0;
        chk(ADDR_EXPAND, 16'h0000);
        foreach (holes[k])
            chk(holes[k], 16'h0000);
        // second reset in mid-run restores the advertisement
        rst_b = 1'b0;
        cyc(1);
        cmp(advWord, 16'h0000);
        rst_b = 1'b1;
        cyc(2);
        cmp(advWord, 16'h05e1);
        chk(ADDR_ADVERT, 16'h05e1);
        final_report();
    end
endmodule
`default_nettype wire
